// ===== core/hlo_pkg.sv
// package of constants for the handshake line output control block
package hlo_pkg;
    // register byte offsets on the bus
    localparam logic [3:0] HLO_PORT_A_DATA_OFF = 4'h0;
    localparam logic [3:0] HLO_PORT_A_CTRL_OFF = 4'h4;
    localparam logic [3:0] HLO_PORT_B_DATA_OFF = 4'h8;
    localparam logic [3:0] HLO_PORT_B_CTRL_OFF = 4'hC;
    // control register field positions
    localparam int HLO_EDGE_POL_BIT = 1;
    localparam int HLO_DATA_SEL_BIT = 2;
    localparam int HLO_LINE_LEVEL_BIT = 3;
    localparam int HLO_MODE_LO_BIT = 3;
    localparam int HLO_MODE_HI_BIT = 5;
    localparam int HLO_EDGE_FLAG_BIT = 7;
    // mode field encodings (bits five to three)
    localparam logic [2:0] HLO_MODE_HANDSHAKE = 3'h4;
    localparam logic [2:0] HLO_MODE_PULSE = 3'h5;
    localparam logic [2:0] HLO_MODE_MAN_LOW = 3'h6;
    localparam logic [2:0] HLO_MODE_MAN_HIGH = 3'h7;
    // reset values
    localparam logic [7:0] HLO_CTRL_RST = 8'h00;
    localparam logic [7:0] HLO_DATA_RST = 8'h00;
    localparam logic HLO_LINE_RST = 1'b1;
    // length of the strobe pulse in clock cycles
    localparam int HLO_PULSE_CYCLES = 1;
endpackage

// ===== core/hlo_port_if.sv
// interface carrying one port's control and event signals
`timescale 1ns/100ps
interface hlo_port_if;
    logic [7:0] ctrl; // control register value
    logic edge_in; // first control line input
    logic access; // qualifying data access pulse
    logic edge_seen; // active edge detected pulse
    logic line; // second control line level
    modport core (input ctrl, input edge_in, input access, output edge_seen, output line);
    modport top (output ctrl, output edge_in, output access, input edge_seen, input line);
endinterface

// ===== core/hlo_line_ctrl.sv
// per-port edge detect and second control line generator
`timescale 1ns/100ps
module hlo_line_ctrl
    import hlo_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // port signals
    hlo_port_if.core p
);
    logic edge_prev; // last sampled edge input
    logic next_edge_prev;
    logic line_q; // line level register
    logic next_line;
    logic edge_hit; // active edge this cycle
    logic [2:0] mode; // mode field

    // edge polarity from bit one
    always_comb begin
        mode = p.ctrl[HLO_MODE_HI_BIT:HLO_MODE_LO_BIT];
        next_edge_prev = p.edge_in;
        if (p.ctrl[HLO_EDGE_POL_BIT]) begin
            edge_hit = p.edge_in & ~edge_prev;
        end else begin
            edge_hit = ~p.edge_in & edge_prev;
        end
    end

    // line next value per mode
    always_comb begin
        next_line = line_q;
        case (mode)
            HLO_MODE_HANDSHAKE: begin
                // access clears, edge sets; clear wins if both
                if (p.access) begin
                    next_line = 1'b0; // R2 R5 R11
                end else if (edge_hit) begin
                    next_line = 1'b1; // R1 R6
                end
            end
            HLO_MODE_PULSE: begin
                // one-cycle low after the access
                next_line = ~p.access; // R3 R7 R11
            end
            HLO_MODE_MAN_LOW, HLO_MODE_MAN_HIGH: begin
                next_line = p.ctrl[HLO_LINE_LEVEL_BIT]; // R4 R8
            end
            default: begin
                // input modes: line idles high
                next_line = 1'b1;
            end
        endcase
    end

    // registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            edge_prev <= 1'b0;
            line_q <= HLO_LINE_RST;
        end else begin
            edge_prev <= next_edge_prev;
            line_q <= next_line; // R11
        end
    end

    assign p.line = line_q;
    assign p.edge_seen = edge_hit;
endmodule

// ===== core/hlo_top.sv
// top: ahb-lite registers and two handshake line controllers
`timescale 1ns/100ps
// Function
// R1 - port A handshake: edge sets line high
// R2 - port A handshake: data read clears line
// R3 - port A pulse: one low cycle after read
// R4 - port A manual: line follows bit three
// R5 - port B handshake: data write clears line
// R6 - port B handshake: edge sets line high
// R7 - port B pulse: one low cycle after write
// R8 - port B manual: line follows bit three
// R9 - active edge sets control bit seven
// R10 - data read needs select zero, bit two set
// R11 - updates clocked, pulse starts next cycle; the output pins lag one more cycle through line_a_q and line_b_q
module hlo_top
    import hlo_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // peripheral lines
    input wire logic port_a_edge_input,
    input wire logic port_b_edge_input,
    output logic port_a_handshake_line,
    output logic port_b_handshake_line
);
    logic [7:0] port_a_control_reg; // port A control
    logic [7:0] port_b_control_reg; // port B control
    logic [7:0] port_a_output_reg; // port A data
    logic [7:0] port_b_output_reg; // port B data
    logic [7:0] next_ctrl_a, next_ctrl_b, next_data_a, next_data_b;
    logic wr_pend; // pending write data phase
    logic [3:0] wr_off; // latched write offset
    logic next_wr_pend;
    logic [3:0] next_wr_off;
    logic [31:0] next_hrdata;
    logic rd_a_data, wr_b_data, rd_ctrl_a, rd_ctrl_b; // decoded events
    logic addr_ok; // valid address phase
    logic [3:0] off; // address offset
    logic line_a_q, line_b_q; // output registers

    hlo_port_if pa();
    hlo_port_if pb();

    // address phase decode
    always_comb begin
        addr_ok = hsel & hready & htrans[1];
        off = haddr[3:0];
        // R10: data read with select zero and bit two set
        rd_a_data = addr_ok & ~hwrite & (off == HLO_PORT_A_DATA_OFF) & port_a_control_reg[HLO_DATA_SEL_BIT];
        rd_ctrl_a = addr_ok & ~hwrite & (off == HLO_PORT_A_CTRL_OFF);
        rd_ctrl_b = addr_ok & ~hwrite & (off == HLO_PORT_B_CTRL_OFF);
        // write of port B data, select bit two set
        wr_b_data = wr_pend & (wr_off == HLO_PORT_B_DATA_OFF) & port_b_control_reg[HLO_DATA_SEL_BIT];
        next_wr_pend = addr_ok & hwrite;
        next_wr_off = off;
    end

    // read data, captured at address phase for next-cycle data phase
    always_comb begin
        next_hrdata = 32'h0000_0000;
        if (addr_ok & ~hwrite) begin
            case (off)
                HLO_PORT_A_DATA_OFF: next_hrdata = {24'h00_0000, port_a_output_reg};
                HLO_PORT_A_CTRL_OFF: next_hrdata = {24'h00_0000, port_a_control_reg};
                HLO_PORT_B_DATA_OFF: next_hrdata = {24'h00_0000, port_b_output_reg};
                HLO_PORT_B_CTRL_OFF: next_hrdata = {24'h00_0000, port_b_control_reg};
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    // register next values; flag set beats data read clear
    always_comb begin
        next_ctrl_a = port_a_control_reg;
        next_ctrl_b = port_b_control_reg;
        next_data_a = port_a_output_reg;
        next_data_b = port_b_output_reg;
        // flag cleared by reading port data
        if (rd_a_data) begin
            next_ctrl_a[HLO_EDGE_FLAG_BIT] = 1'b0;
        end
        if (wr_pend) begin
            case (wr_off)
                HLO_PORT_A_DATA_OFF: next_data_a = hwdata[7:0];
                HLO_PORT_B_DATA_OFF: next_data_b = hwdata[7:0];
                HLO_PORT_A_CTRL_OFF: next_ctrl_a[6:0] = hwdata[6:0];
                HLO_PORT_B_CTRL_OFF: next_ctrl_b[6:0] = hwdata[6:0];
                default: ;
            endcase
        end
        // flag cleared by port B data read
        if (addr_ok & ~hwrite & (off == HLO_PORT_B_DATA_OFF) & port_b_control_reg[HLO_DATA_SEL_BIT]) begin
            next_ctrl_b[HLO_EDGE_FLAG_BIT] = 1'b0;
        end
        // edge sets flag regardless of bit zero
        if (pa.edge_seen) begin
            next_ctrl_a[HLO_EDGE_FLAG_BIT] = 1'b1; // R9
        end
        if (pb.edge_seen) begin
            next_ctrl_b[HLO_EDGE_FLAG_BIT] = 1'b1; // R9
        end
    end

    // register state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_a_control_reg <= HLO_CTRL_RST;
            port_b_control_reg <= HLO_CTRL_RST;
            port_a_output_reg <= HLO_DATA_RST;
            port_b_output_reg <= HLO_DATA_RST;
            wr_pend <= 1'b0;
            wr_off <= 4'h0;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            line_a_q <= HLO_LINE_RST;
            line_b_q <= HLO_LINE_RST;
        end else begin
            port_a_control_reg <= next_ctrl_a;
            port_b_control_reg <= next_ctrl_b;
            port_a_output_reg <= next_data_a;
            port_b_output_reg <= next_data_b;
            wr_pend <= next_wr_pend;
            wr_off <= next_wr_off;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            line_a_q <= pa.line;
            line_b_q <= pb.line;
        end
    end

    // connect port controllers
    assign pa.ctrl = port_a_control_reg;
    assign pa.edge_in = port_a_edge_input;
    assign pa.access = rd_a_data; // R2 R3
    assign pb.ctrl = port_b_control_reg;
    assign pb.edge_in = port_b_edge_input;
    assign pb.access = wr_b_data; // R5 R7

    hlo_line_ctrl u_line_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .p(pa.core)
    );

    hlo_line_ctrl u_line_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .p(pb.core)
    );

    // outputs straight from flip-flops
    always_comb begin
        port_a_handshake_line = line_a_q;
        port_b_handshake_line = line_b_q;
    end
endmodule

// ===== dv/hlo_top_properties.sv
// checker bound to hlo_top watching its pins
`timescale 1ns/100ps
module hlo_chk
    import hlo_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    // lines
    input wire logic port_a_edge_input,
    input wire logic port_b_edge_input,
    input wire logic port_a_handshake_line,
    input wire logic port_b_handshake_line
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [7:0] ca, cb; // shadow control values
    logic [3:0] wo; // offset of pending write
    logic wp; // write data phase due
    wire take = hsel && hready && htrans[1];
    wire rd_a = take && !hwrite && haddr[3:0] == HLO_PORT_A_DATA_OFF && ca[2];
    wire wr_b = take && hwrite && haddr[3:0] == HLO_PORT_B_DATA_OFF && cb[2];
    wire la = port_a_handshake_line;
    wire lb = port_b_handshake_line;
    // follow control writes at their data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {wp, wo, ca, cb} <= '0;
        end else begin
            wp <= take && hwrite;
            wo <= haddr[3:0];
            if (wp && wo == HLO_PORT_A_CTRL_OFF) ca <= hwdata[7:0];
            if (wp && wo == HLO_PORT_B_CTRL_OFF) cb <= hwdata[7:0];
        end
    end
    // one low cycle, then high again
    sequence s_strobe_a;
        !la ##1 la;
    endsequence
    sequence s_strobe_b;
        !lb ##1 lb;
    endsequence
    a_read_clears_a: assert property (rd_a && ca[5:3] == HLO_MODE_HANDSHAKE |-> ##3 !la)
        else $error("a not cleared");
    a_pulse_after_read: assert property (rd_a && ca[5:3] == HLO_MODE_PULSE |-> ##2 s_strobe_a)
        else $error("a pulse wrong");
    a_write_clears_b: assert property (wr_b && cb[5:3] == HLO_MODE_HANDSHAKE |-> ##3 !lb)
        else $error("b not cleared");
    a_pulse_after_write: assert property (wr_b && cb[5:3] == HLO_MODE_PULSE |-> ##3 s_strobe_b)
        else $error("b pulse wrong");
    a_edge_sets_a: assert property (ca[5:3] == HLO_MODE_HANDSHAKE &&
        (ca[1] ? $rose(port_a_edge_input) : $fell(port_a_edge_input)) |-> ##[1:6] la)
        else $error("a not set");
    a_edge_sets_b: assert property (cb[5:3] == HLO_MODE_HANDSHAKE &&
        (cb[1] ? $rose(port_b_edge_input) : $fell(port_b_edge_input)) |-> ##[1:6] lb)
        else $error("b not set");
    a_manual_level_a: assert property (($stable(ca) && ca[5:4] == 2'b11)[*6] |-> la == ca[3])
        else $error("a manual wrong");
    a_manual_level_b: assert property (($stable(cb) && cb[5:4] == 2'b11)[*6] |-> lb == cb[3])
        else $error("b manual wrong");
endmodule
bind hlo_top hlo_chk u_hlo_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .port_a_edge_input, .port_b_edge_input, .port_a_handshake_line, .port_b_handshake_line);

// ===== dv/hlo_periph.sv
// peripheral model driving the two edge inputs
`timescale 1ns/100ps
module hlo_periph (
    // clock
    input wire logic hclk,
    // edge lines toward the block
    output logic edge_a,
    output logic edge_b
);
    initial edge_a = 1'b0;
    initial edge_b = 1'b0;
    // toggle one line just after a rising edge, then hold it
    task automatic flip(input logic p);
        @(posedge hclk);
        if (p) edge_b <= ~edge_b;
        else edge_a <= ~edge_a;
    endtask
endmodule

// ===== dv/hlo_top_tb_top.sv
// testbench for the handshake line output block
`timescale 1ns/100ps
module hlo_top_tb_top
    import hlo_pkg::*;
;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic hreadyout, hresp, ea, eb, la, lb;
    wire hready = hreadyout; // single slave drives bus ready
    int err_count = 0, checks = 0;
    always #20 hclk = ~hclk;
    hlo_top u_hlo_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .port_a_edge_input(ea), .port_b_edge_input(eb),
        .port_a_handshake_line(la), .port_b_handshake_line(lb));
    hlo_periph u_hlo_periph (.hclk, .edge_a(ea), .edge_b(eb));
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    // one single ahb-lite transfer, read data left in r
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int i;
        @(posedge hclk);
        {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, a, w};
        i = 0;
        do begin @(posedge hclk); i++; end while (hready !== 1'b1 && i < 9);
        if (hready !== 1'b1) err_count++;
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
        i = 0;
        do begin @(posedge hclk); i++; end while (hready !== 1'b1 && i < 9);
        if (hready !== 1'b1) err_count++;
        r = hrdata;
        cmp({hreadyout, hresp}, 2'b10);
    endtask
    task automatic lvl(input logic p, input logic e);
        repeat (6) @(negedge hclk);
        cmp(p ? lb : la, e);
    endtask
    task automatic pulse(input logic p);
        int n;
        n = 0;
        repeat (8) begin @(negedge hclk); n += ((p ? lb : la) === 1'b0); end
        cmp(n, 1);
    endtask
    task automatic t_manual;
        for (int p = 0; p < 2; p++) for (int v = 6; v < 8; v++) begin
            bus(1'b1, p ? 32'hC : 32'h4, {v[2:0], 3'h0});
            lvl(p[0], v[0]);
        end
        $display("manual done");
    endtask
    task automatic t_hs_a;
        bus(1'b1, 32'h4, 32'h26);
        bus(1'b0, 32'h0, 32'h0);
        lvl(1'b0, 1'b0);
        bus(1'b1, 32'h4, 32'h22);
        u_hlo_periph.flip(1'b0);
        lvl(1'b0, 1'b1);
        bus(1'b0, 32'h0, 32'h0);
        lvl(1'b0, 1'b1);
        bus(1'b0, 32'h4, 32'h0);
        cmp(r, 32'hA2);
        $display("handshake a done");
    endtask
    task automatic t_hs_b;
        bus(1'b1, 32'hC, 32'h24);
        bus(1'b1, 32'h8, 32'h5A);
        lvl(1'b1, 1'b0);
        u_hlo_periph.flip(1'b1);
        lvl(1'b1, 1'b0);
        bus(1'b0, 32'hC, 32'h0);
        cmp(r, 32'h24);
        u_hlo_periph.flip(1'b1);
        lvl(1'b1, 1'b1);
        bus(1'b0, 32'hC, 32'h0);
        cmp(r, 32'hA4);
        bus(1'b0, 32'h10, 32'h0);
        cmp(r, 32'h0);
        $display("handshake b done");
    endtask
    task automatic t_pulses;
        bus(1'b1, 32'h4, 32'h2E);
        bus(1'b0, 32'h0, 32'h0);
        pulse(1'b0);
        bus(1'b1, 32'hC, 32'h2C);
        bus(1'b1, 32'h8, 32'hA5);
        pulse(1'b1);
        $display("pulses done");
    endtask
    task automatic summarize;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        cmp({la, lb}, 2'b11);
        t_manual;
        t_hs_a;
        t_hs_b;
        t_pulses;
        summarize;
    end
    initial begin
        #100000;
        err_count++;
        summarize;
    end
endmodule
